/* hw/clksyn_pkg.sv */
package clksyn_pkg;

  // Register window on the serial port
  localparam logic [7:0] REG_BASE  = 8'h17;
  localparam logic [7:0] REG_LAST  = 8'h1f;
  localparam int         REG_COUNT = 9;

  localparam logic [7:0] OFS_SPREAD_PERIOD_LOW = 8'h17;
  localparam logic [7:0] OFS_PLL_B_CONTROL     = 8'h18;
  localparam logic [7:0] OFS_CHARGE_PUMP       = 8'h19;
  localparam logic [7:0] OFS_REF_DIVIDER       = 8'h1a;
  localparam logic [7:0] OFS_OUT_DIV_C_D       = 8'h1b;
  localparam logic [7:0] OFS_PLL_OPERATION     = 8'h1c;
  localparam logic [7:0] OFS_OUTPUT_CONTROL    = 8'h1d;
  localparam logic [7:0] OFS_ENABLE_PRESET     = 8'h1e;
  localparam logic [7:0] OFS_LOOP_ORDER        = 8'h1f;

  // Power-up values, indexed from the window base
  localparam logic [7:0] REG_RESET [0:8] = '{8'h00, 8'h0e, 8'h14, 8'h19, 8'h43,
                                             8'h3f, 8'h33, 8'h90, 8'h84};
  // Writable bits; the rest keep their power-up value
  localparam logic [7:0] REG_WMASK [0:8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                                             8'hff, 8'hff, 8'he3, 8'h0e};

  // Field positions
  localparam int POS_SPREAD_EN      = 5;
  localparam int POS_SEG_ONLY_MIN   = 0;
  localparam int POS_BIAS_SEL       = 0;
  localparam int POS_REF_DOUBLER    = 7;
  localparam int POS_REF_BYP1       = 6;
  localparam int POS_REF_BYP2       = 5;
  localparam int POS_FINE_STEP      = 7;
  localparam int POS_REF_SOURCE     = 6;
  localparam int POS_DIFF_A_GATED   = 7;
  localparam int POS_DIFF_B_GATED   = 6;
  localparam int POS_DIFF_A_ON      = 5;
  localparam int POS_DIFF_B_ON      = 4;
  localparam int POS_DIV_D_SOURCE   = 3;
  localparam int POS_SE_EDGE        = 2;
  localparam int POS_SE_ON          = 7;
  localparam int POS_LOOP_ORDER     = 3;
  localparam int POS_CHAN_TWO_ON    = 2;
  localparam int POS_EXTRA_POLE     = 1;

  // Roles of the multi-function enable pin
  localparam logic [1:0] ROLE_SE_ENABLE = 2'h0;
  localparam logic [1:0] ROLE_PWR_DOWN  = 2'h1;
  localparam logic [1:0] ROLE_PWR_SAVE  = 2'h2;
  localparam logic [1:0] ROLE_PRESET0   = 2'h3;

  // Fine spread stepping shifts the step value by this many bits
  localparam logic [2:0] FINE_STEP_SHIFT = 3'h4;

  // Serial port receiver states
  typedef enum logic [8:0] {
    CS_IDLE   = 9'h001,
    CS_ADDR   = 9'h002,
    CS_AACK   = 9'h004,
    CS_OFS    = 9'h008,
    CS_OACK   = 9'h010,
    CS_WDATA  = 9'h020,
    CS_WACK   = 9'h040,
    CS_RDATA  = 9'h080,
    CS_RACK   = 9'h100
  } clksyn_state_t;

  typedef struct packed {
    logic [9:0] pll_b_spread_period;
    logic       pll_b_spread_enable;
    logic [4:0] loop_res_seg;        // largest, large, mid, small, only_min
    logic [6:0] pump_scale;          // x16, x8, x4, x2, x1, /24, /3
    logic       pll_b_bias_current_sel;
    logic       pll_b_ref_doubler;
    logic       pll_b_ref_bypass_div1;
    logic       pll_b_ref_bypass_div2;
    logic [4:0] pll_b_ref_divide;
    logic [3:0] out_divider_c;
    logic [3:0] out_divider_d;
    logic       pll_b_fine_spread_step;
    logic       pll_b_ref_source;
    logic [2:0] pll_run;             // c, b, a
    logic [2:0] pll_lock_use;        // c, b, a
    logic       diff_out_a_pin_gated;
    logic       diff_out_b_pin_gated;
    logic       diff_out_a_on;
    logic       diff_out_b_on;
    logic       out_divider_d_source;
    logic       single_out_a_edge_rate;
    logic [1:0] single_out_a_level;
    logic       single_out_a_on;
    logic [1:0] multi_pin_role;
    logic [1:0] freq_preset_select;
    logic       pll_b_loop_order;
    logic       pll_b_channel_two_on;
    logic       pll_b_extra_pole;
  } clksyn_cfg_t;

  typedef struct packed {
    logic       diff_out_a_active;
    logic       diff_out_b_active;
    logic       single_out_a_active;
    logic       power_down_low;
    logic       single_out_a_power_save;
    logic [1:0] dynamic_freq_switch;
    logic [4:0] loop_res_applied;
    logic [2:0] spread_step_shift;
  } clksyn_eff_t;

endpackage

/* hw/clksyn_regs.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Ten-bit spread period: low byte at 0x17, top two bits in 0x18[7:6], reset zero.
// RULE_02: Bit 5 of 0x18 turns spread modulation of the second loop on; reset off.
// RULE_03: Bits 4:1 of 0x18 add resistor segments; bit 0 alone applies smallest only.
// RULE_04: Bits 7:1 of 0x19 scale pump current; x2 and divide-by-24 set at reset.
// RULE_05: Bit 0 of 0x19 doubles the reference bias current when set; reset clear.
// RULE_06: Bits 4:0 of 0x1a hold reference divide, reset 25; bit 7 enables doubler.
// RULE_07: Bits 6 and 5 of 0x1a pick fixed divide-by-1 and divide-by-2 bypass paths.
// RULE_08: Byte 0x1b holds third divider (upper, reset 4) and fourth divider (lower, reset 3).
// RULE_09: 0x1c bits 5,3,1 run loops three,two,one; bits 4,2,0 use lock; all reset 1.
// RULE_10: Bit 7 of 0x1c selects fine spread stepping, shifting step by four bits.
// RULE_11: Bit 6 of 0x1c feeds the second loop from second divider instead of crystal.
// RULE_12: Bits 7 and 6 of 0x1d put differential outputs under the second enable pin.
// RULE_13: Bits 5 and 4 of 0x1d enable differential outputs one and two; reset enabled.
// RULE_14: Bit 3 of 0x1d clocks the fourth divider from crystal instead of the loop.
// RULE_15: Bit 2 of 0x1d selects strong edge rate for the single output; reset normal.
// RULE_16: Bits 1:0 of 0x1d select single output supply level; reset code 11.
// RULE_17: Bit 7 of 0x1e enables the single-ended output; reset enabled.
// RULE_18: Bits 6:5 of 0x1e set the multi-function pin role; reset output-enable role.
// RULE_19: Bits 1:0 of 0x1e pick one of four frequency presets; reset preset zero.
// RULE_20: Bit 3 of 0x1f makes the second loop third order; reset first order.
// RULE_21: Bit 2 of 0x1f enables the second loop channel two path; reset enabled.
// RULE_22: Bit 1 of 0x1f enables the extra loop pole; reset disabled.
// RULE_23: Reserved bits keep power-up values; writes to them are ignored.
module clksyn_regs
  import clksyn_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h68    // Arbitrary bus address
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  input  wire logic        SECOND_ENABLE_PIN,
  input  wire logic        MULTI_PIN,
  output clksyn_cfg_t      CFG,
  output clksyn_eff_t      EFF
);

  logic [2:0]    scl_sync;
  logic [2:0]    sda_sync;
  logic [1:0]    oe2_sync;
  logic [1:0]    multi_sync;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_seen;
  logic          stop_seen;
  clksyn_state_t state;
  clksyn_state_t next_state;
  logic [7:0]    shreg;
  logic [3:0]    bit_cnt;
  logic [7:0]    ptr;
  logic          read_dir;
  logic          master_ack;
  logic          byte_done;
  logic          wr_fire;
  logic          rd_load;
  logic [7:0]    rd_byte;
  logic [7:0]    regs [0:8];
  clksyn_cfg_t   next_cfg;
  clksyn_eff_t   next_eff;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge MCLK) begin
    if (RST) begin
      scl_sync   <= 3'h7;
      sda_sync   <= 3'h7;
      oe2_sync   <= 2'h0;
      multi_sync <= 2'h0;
    end else begin
      scl_sync   <= {scl_sync[1:0], SCL_IN};
      sda_sync   <= {sda_sync[1:0], SDA_IN};
      oe2_sync   <= {oe2_sync[0], SECOND_ENABLE_PIN};
      multi_sync <= {multi_sync[0], MULTI_PIN};
    end
  end

  // Bus events from the settled stages only
  assign scl_rise   = scl_sync[1] & ~scl_sync[2];
  assign scl_fall   = ~scl_sync[1] & scl_sync[2];
  assign start_seen = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
  assign stop_seen  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];
  assign byte_done  = scl_fall && (bit_cnt == 4'h8);
  assign wr_fire    = (state == CS_WDATA) && byte_done;
  assign rd_load    = scl_fall && (((state == CS_AACK) && read_dir) || ((state == CS_RACK) && master_ack));

  // Read data; outside the window reads as zero
  always_comb begin
    rd_byte = 8'h00;
    if (ptr >= REG_BASE && ptr <= REG_LAST) begin
      rd_byte = regs[4'(ptr - REG_BASE)];
    end
  end

  // Next state of the serial receiver
  always_comb begin
    next_state = state;
    unique case (state)
      CS_IDLE:  next_state = CS_IDLE;
      CS_ADDR:  if (byte_done) begin
        next_state = (shreg[7:1] == DEV_ADDR) ? CS_AACK : CS_IDLE;
      end
      CS_AACK:  if (scl_fall) begin
        next_state = read_dir ? CS_RDATA : CS_OFS;
      end
      CS_OFS:   if (byte_done) begin
        next_state = CS_OACK;
      end
      CS_OACK:  if (scl_fall) begin
        next_state = CS_WDATA;
      end
      CS_WDATA: if (byte_done) begin
        next_state = CS_WACK;
      end
      CS_WACK:  if (scl_fall) begin
        next_state = CS_WDATA;
      end
      CS_RDATA: if (scl_fall && bit_cnt == 4'h7) begin
        next_state = CS_RACK;
      end
      CS_RACK:  if (scl_fall) begin
        next_state = master_ack ? CS_RDATA : CS_IDLE;
      end
    endcase
    // Start and stop override any phase, including a repeated start
    if (start_seen) begin
      next_state = CS_ADDR;
    end else if (stop_seen) begin
      next_state = CS_IDLE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state <= CS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Direction bit and master acknowledge capture
  always_ff @(posedge MCLK) begin
    if (RST) begin
      read_dir   <= 1'b0;
      master_ack <= 1'b0;
    end else begin
      if (state == CS_ADDR && byte_done) begin
        read_dir <= shreg[0];
      end
      if (state == CS_RACK && scl_rise) begin
        master_ack <= ~sda_sync[1];
      end
    end
  end

  // Shift register and bit counter
  always_ff @(posedge MCLK) begin
    if (RST) begin
      shreg   <= 8'h00;
      bit_cnt <= 4'h0;
    end else if (start_seen) begin
      bit_cnt <= 4'h0;
    end else if (rd_load) begin
      shreg   <= rd_byte;
      bit_cnt <= 4'h0;
    end else if (state == CS_RDATA) begin
      if (scl_fall) begin
        shreg   <= {shreg[6:0], 1'b0};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end else if (state == CS_ADDR || state == CS_OFS || state == CS_WDATA) begin
      if (scl_rise) begin
        shreg   <= {shreg[6:0], sda_sync[1]};
        bit_cnt <= bit_cnt + 4'h1;
      end
    end else if (scl_fall) begin
      bit_cnt <= 4'h0;
    end
  end

  // Register pointer, advancing after each byte written or loaded
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ptr <= 8'h00;
    end else if (state == CS_OFS && byte_done) begin
      ptr <= shreg;
    end else if (wr_fire || rd_load) begin
      ptr <= ptr + 8'h01;
    end
  end

  // Data line: pull low for acknowledge and for read zeros
  always_ff @(posedge MCLK) begin
    if (RST) begin
      SDA_OUT  <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      SDA_OUT <= 1'b0;
      if (start_seen || stop_seen) begin
        SDA_OE_N <= 1'b1;
      end else if (byte_done && ((state == CS_ADDR && shreg[7:1] == DEV_ADDR)
                                 || state == CS_OFS || state == CS_WDATA)) begin
        SDA_OE_N <= 1'b0;
      end else if (rd_load) begin
        SDA_OE_N <= rd_byte[7];
      end else if (state == CS_RDATA && scl_fall) begin
        SDA_OE_N <= (bit_cnt == 4'h7) ? 1'b1 : shreg[6];
      end else if (scl_fall && (state == CS_AACK || state == CS_OACK || state == CS_WACK)) begin
        SDA_OE_N <= 1'b1;
      end
    end
  end

  // Register bytes; reserved bits are forced back to power-up value
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
    always_ff @(posedge MCLK) begin
      if (RST) begin
        regs[i] <= REG_RESET[i];                                     // [RULE_23]
      end else if (wr_fire && ptr == REG_BASE + 8'(i)) begin
        regs[i] <= (shreg & REG_WMASK[i]) | (REG_RESET[i] & ~REG_WMASK[i]); // [RULE_23]
      end
    end
  end

  // Field map from the register bytes
  always_comb begin
    next_cfg.pll_b_spread_period    = {regs[1][7:6], regs[0]};                 // [RULE_01]
    next_cfg.pll_b_spread_enable    = regs[1][POS_SPREAD_EN];                  // [RULE_02]
    next_cfg.loop_res_seg           = regs[1][4:0];                            // [RULE_03]
    next_cfg.pump_scale             = regs[2][7:1];                            // [RULE_04]
    next_cfg.pll_b_bias_current_sel = regs[2][POS_BIAS_SEL];                   // [RULE_05]
    next_cfg.pll_b_ref_doubler      = regs[3][POS_REF_DOUBLER];                // [RULE_06]
    next_cfg.pll_b_ref_bypass_div1  = regs[3][POS_REF_BYP1];                   // [RULE_07]
    next_cfg.pll_b_ref_bypass_div2  = regs[3][POS_REF_BYP2];                   // [RULE_07]
    next_cfg.pll_b_ref_divide       = regs[3][4:0];                            // [RULE_06]
    next_cfg.out_divider_c          = regs[4][7:4];                            // [RULE_08]
    next_cfg.out_divider_d          = regs[4][3:0];                            // [RULE_08]
    next_cfg.pll_b_fine_spread_step = regs[5][POS_FINE_STEP];                  // [RULE_10]
    next_cfg.pll_b_ref_source       = regs[5][POS_REF_SOURCE];                 // [RULE_11]
    next_cfg.pll_run                = {regs[5][5], regs[5][3], regs[5][1]};    // [RULE_09]
    next_cfg.pll_lock_use           = {regs[5][4], regs[5][2], regs[5][0]};    // [RULE_09]
    next_cfg.diff_out_a_pin_gated   = regs[6][POS_DIFF_A_GATED];               // [RULE_12]
    next_cfg.diff_out_b_pin_gated   = regs[6][POS_DIFF_B_GATED];               // [RULE_12]
    next_cfg.diff_out_a_on          = regs[6][POS_DIFF_A_ON];                  // [RULE_13]
    next_cfg.diff_out_b_on          = regs[6][POS_DIFF_B_ON];                  // [RULE_13]
    next_cfg.out_divider_d_source   = regs[6][POS_DIV_D_SOURCE];               // [RULE_14]
    next_cfg.single_out_a_edge_rate = regs[6][POS_SE_EDGE];                    // [RULE_15]
    next_cfg.single_out_a_level     = regs[6][1:0];                            // [RULE_16]
    next_cfg.single_out_a_on        = regs[7][POS_SE_ON];                      // [RULE_17]
    next_cfg.multi_pin_role         = regs[7][6:5];                            // [RULE_18]
    next_cfg.freq_preset_select     = regs[7][1:0];                            // [RULE_19]
    next_cfg.pll_b_loop_order       = regs[8][POS_LOOP_ORDER];                 // [RULE_20]
    next_cfg.pll_b_channel_two_on   = regs[8][POS_CHAN_TWO_ON];                // [RULE_21]
    next_cfg.pll_b_extra_pole       = regs[8][POS_EXTRA_POLE];                 // [RULE_22]
  end

  // Effective controls combining fields with the enable pins
  always_comb begin
    next_eff.diff_out_a_active = next_cfg.diff_out_a_on
                                 & (~next_cfg.diff_out_a_pin_gated | oe2_sync[1]);  // [RULE_12]
    next_eff.diff_out_b_active = next_cfg.diff_out_b_on
                                 & (~next_cfg.diff_out_b_pin_gated | oe2_sync[1]);  // [RULE_12]
    next_eff.single_out_a_active = next_cfg.single_out_a_on
                                   & ((next_cfg.multi_pin_role != ROLE_SE_ENABLE) | multi_sync[1]); // [RULE_18]
    next_eff.power_down_low = ~((next_cfg.multi_pin_role == ROLE_PWR_DOWN) & ~multi_sync[1]);     // [RULE_18]
    next_eff.single_out_a_power_save = (next_cfg.multi_pin_role == ROLE_PWR_SAVE) & ~multi_sync[1]; // [RULE_18]
    // Pin replaces preset bit zero only in its preset role
    next_eff.dynamic_freq_switch = {next_cfg.freq_preset_select[1],
                                    (next_cfg.multi_pin_role == ROLE_PRESET0) ? multi_sync[1]
                                                                              : next_cfg.freq_preset_select[0]}; // [RULE_19]
    // Only-min segment overrides the others so the loop never sees both
    next_eff.loop_res_applied = next_cfg.loop_res_seg[POS_SEG_ONLY_MIN] ? 5'h01
                                                                         : {next_cfg.loop_res_seg[4:1], 1'b0}; // [RULE_03]
    next_eff.spread_step_shift = next_cfg.pll_b_fine_spread_step ? FINE_STEP_SHIFT : 3'h0;            // [RULE_10]
  end

  // Registered outputs so the analog side sees glitch-free levels
  always_ff @(posedge MCLK) begin
    if (RST) begin
      CFG <= '0;
      EFF <= '0;
    end else begin
      CFG <= next_cfg;
      EFF <= next_eff;
    end
  end

endmodule // clksyn_regs

/* bench/clksyn_regs_assertions.sv */
`timescale 1ns/1ps
// Derived controls must track the register copy and the pins
module clksyn_regs_assertions
  import clksyn_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        MULTI_PIN,
  input wire logic        SECOND_ENABLE_PIN,
  input wire clksyn_cfg_t CFG,
  input wire clksyn_eff_t EFF
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // Power-up values land on the first edge after release
  property p_reset_values;
    $fell(RST) |-> ##1 (CFG.pll_run == 3'h7 && CFG.pll_lock_use == 3'h7 && CFG.out_divider_c == 4'h4 &&
                        CFG.out_divider_d == 4'h3 && CFG.pll_b_ref_divide == 5'h19);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad power-up values");
  property p_res_applied;
    $stable(CFG.loop_res_seg) [*2] |->
      EFF.loop_res_applied == (CFG.loop_res_seg[0] ? 5'h01 : {CFG.loop_res_seg[4:1], 1'b0});
  endproperty
  a_res_applied: assert property (p_res_applied) else $error("resistor segments wrong");
  property p_step_shift;
    $stable(CFG.pll_b_fine_spread_step) [*2] |->
      EFF.spread_step_shift == (CFG.pll_b_fine_spread_step ? 3'h4 : 3'h0);
  endproperty
  a_step_shift: assert property (p_step_shift) else $error("step shift wrong");
  // Pins pass a synchroniser, so each pin relation waits six cycles
  property p_diff_off;
    (!CFG.diff_out_a_on || (CFG.diff_out_a_pin_gated && !SECOND_ENABLE_PIN)) [*6] |-> !EFF.diff_out_a_active;
  endproperty
  a_diff_off: assert property (p_diff_off) else $error("diff output a not off");
  property p_diff_on;
    (CFG.diff_out_b_on && (!CFG.diff_out_b_pin_gated || SECOND_ENABLE_PIN)) [*6] |-> EFF.diff_out_b_active;
  endproperty
  a_diff_on: assert property (p_diff_on) else $error("diff output b not on");
  property p_pwr_down;
    (CFG.multi_pin_role == ROLE_PWR_DOWN && !MULTI_PIN) [*6] |-> !EFF.power_down_low;
  endproperty
  a_pwr_down: assert property (p_pwr_down) else $error("power-down role ignored");
  property p_power_save;
    (CFG.multi_pin_role == ROLE_PWR_SAVE && !MULTI_PIN) [*6] |-> EFF.single_out_a_power_save;
  endproperty
  a_power_save: assert property (p_power_save) else $error("power-save role ignored");
  property p_preset;
    ($stable(CFG) && CFG.multi_pin_role != ROLE_PRESET0) [*6] |-> EFF.dynamic_freq_switch == CFG.freq_preset_select;
  endproperty
  a_preset: assert property (p_preset) else $error("preset select wrong");
endmodule // clksyn_regs_assertions
bind clksyn_regs clksyn_regs_assertions u_chk (.MCLK(MCLK), .RST(RST), .MULTI_PIN(MULTI_PIN),
  .SECOND_ENABLE_PIN(SECOND_ENABLE_PIN), .CFG(CFG), .EFF(EFF));

/* bench/clksyn_host.sv */
`timescale 1ns/1ps
// Serial bus master in the host's place
module clksyn_host (
  input  wire logic clk,
  input  wire logic line,
  output logic      scl = 1'b1,
  output logic      sda = 1'b1
);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves mid low phase only, so no false start or stop
  task automatic xbit(input logic b, output logic r);
    sda <= b;
    tick(4);
    scl <= 1'b1;
    tick(8);
    r = line;
    scl <= 1'b0;
    tick(4);
  endtask
  // Also serves as repeated start while the clock is low
  task automatic start();
    sda <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda <= 1'b0;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda <= 1'b1;
    tick(8);
  endtask
  // Eight bits MSB first, then the ninth clock
  task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
      q[i] = r;
    end
    xbit(ab, a);
  endtask
endmodule // clksyn_host

/* bench/clksyn_regs_bench.sv */
`timescale 1ns/1ps
module clksyn_regs_bench
  import clksyn_pkg::*;
;
  localparam logic [6:0] DEV = 7'h68; // Arbitrary bus address
  // Power-up values and writable masks, 0x17 upward
  localparam logic [7:0] RST_V [0:8] = '{8'h00, 8'h0e, 8'h14, 8'h19, 8'h43, 8'h3f, 8'h33, 8'h90, 8'h84};
  localparam logic [7:0] WR_M [0:8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'he3, 8'h0e};
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        SECOND_ENABLE_PIN = 1'b1;
  logic        MULTI_PIN = 1'b1;
  logic        scl;
  logic        sda;
  logic        SDA_OUT;
  logic        SDA_OE_N;
  logic        line;
  logic        ok;
  logic [7:0]  rb [0:15];
  clksyn_cfg_t CFG;
  clksyn_eff_t EFF;
  int          fails = 0;
  int          checks = 0;
  always #2 MCLK = ~MCLK;
  // Open drain: the device wins when it pulls low
  assign line = SDA_OE_N ? sda : SDA_OUT;
  clksyn_host host (.clk(MCLK), .line(line), .scl(scl), .sda(sda));
  clksyn_regs #(.DEV_ADDR(DEV)) dut (.MCLK(MCLK), .RST(RST), .SCL_IN(scl), .SDA_IN(line), .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N), .SECOND_ENABLE_PIN(SECOND_ENABLE_PIN), .MULTI_PIN(MULTI_PIN), .CFG(CFG), .EFF(EFF));
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: output %h expected %h", $time, got, exp);
    end
  endtask
  // n copies of d from ofs; acked is low if the address byte went unanswered
  task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d, input int n,
                    output logic acked);
    logic [7:0] q;
    logic       a;
    host.start();
    host.xbyte({dev, 1'b0}, 1'b1, q, a);
    acked = !a;
    host.xbyte(ofs, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      host.xbyte(d, 1'b1, q, a);
    end
    host.stop();
  endtask
  task automatic rd(input logic [7:0] ofs, input int n);
    logic [7:0] q;
    logic       a;
    host.start();
    host.xbyte({DEV, 1'b0}, 1'b1, q, a);
    host.xbyte(ofs, 1'b1, q, a);
    host.start();
    host.xbyte({DEV, 1'b1}, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      host.xbyte(8'hff, i == n - 1, rb[i], a);
    end
    host.stop();
  endtask
  // Whole window after writing d everywhere, or power-up values
  task automatic chk_table(input logic [7:0] d, input logic use_d);
    rd(8'h17, 9);
    for (int i = 0; i < 9; i++) begin
      chk_rd(rb[i], use_d ? ((d & WR_M[i]) | (RST_V[i] & ~WR_M[i])) : RST_V[i]);
    end
  endtask
  task automatic pulse_reset();
    @(posedge MCLK) RST <= 1'b1;
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    repeat (4) @(posedge MCLK);
  endtask
  initial begin
    pulse_reset();
    chk_table(8'h00, 1'b0);
    wr(DEV, 8'h17, 8'hff, 9, ok);
    chk_out(64'(CFG), '1);
    chk_out(EFF.loop_res_applied, 5'h01);
    chk_out(EFF.spread_step_shift, 3'h4);
    chk_table(8'hff, 1'b1);
    wr(DEV, 8'h17, 8'h00, 9, ok);
    chk_out(64'(CFG), 64'h0);
    chk_out(EFF.spread_step_shift, 3'h0);
    chk_table(8'h00, 1'b1);
    // Period split across two bytes, segments without the minimum
    wr(DEV, 8'h17, 8'h5a, 2, ok);
    chk_out(CFG.pll_b_spread_period, 10'h15a);
    chk_out(EFF.loop_res_applied, 5'h1a);
    wr(DEV, 8'h19, 8'ha5, 1, ok);
    chk_out({CFG.pump_scale, CFG.pll_b_bias_current_sel}, 8'ha5);
    wr(DEV, 8'h1a, 8'hc3, 1, ok);
    chk_out({CFG.pll_b_ref_doubler, CFG.pll_b_ref_bypass_div1, CFG.pll_b_ref_bypass_div2,
             CFG.pll_b_ref_divide}, 8'hc3);
    // Outside the window: acknowledged, dropped, reads zero
    wr(DEV, 8'h20, 8'h55, 1, ok);
    chk_out(ok, 1'b1);
    rd(8'h16, 2);
    chk_rd(rb[0], 8'h00);
    chk_rd(rb[1], 8'h5a);
    wr(DEV ^ 7'h01, 8'h17, 8'h33, 1, ok);
    chk_out(ok, 1'b0);
    rd(8'h17, 1);
    chk_rd(rb[0], 8'h5a);
    // Both differential outputs gated by the second enable pin
    wr(DEV, 8'h1d, 8'hf3, 1, ok);
    for (int p = 0; p < 2; p++) begin
      @(posedge MCLK) SECOND_ENABLE_PIN <= p[0];
      repeat (10) @(posedge MCLK);
      chk_out({EFF.diff_out_a_active, EFF.diff_out_b_active}, {2{p[0]}});
    end
    wr(DEV, 8'h1d, 8'h13, 1, ok);
    @(posedge MCLK) SECOND_ENABLE_PIN <= 1'b0;
    repeat (10) @(posedge MCLK);
    chk_out({EFF.diff_out_a_active, EFF.diff_out_b_active}, 2'b01);
    // Every role of the multi-function pin, pin low then high
    for (int r = 0; r < 4; r++) begin
      wr(DEV, 8'h1e, 8'h82 | 8'(r << 5), 1, ok);
      for (int p = 0; p < 2; p++) begin
        @(posedge MCLK) MULTI_PIN <= p[0];
        repeat (10) @(posedge MCLK);
        case (r)
          0: chk_out(EFF.single_out_a_active, p[0]);
          1: chk_out(EFF.power_down_low, p[0]);
          2: chk_out(EFF.single_out_a_power_save, !p[0]);
          default: chk_out(EFF.dynamic_freq_switch, {1'b1, p[0]});
        endcase
      end
    end
    pulse_reset();
    chk_table(8'h00, 1'b0);
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge MCLK);
    fails++;
    print_verdict();
  end
endmodule // clksyn_regs_bench
